// ---- inc/gpcs_pkg.sv ----
// constants for the per-port pin configuration subregisters and input level registers
// assumes an 8-bit register access path with 12-bit addresses on core_clk
package gpcs_pkg;

	localparam logic [7:0]  ADDR_PAGE      = 8'hFD;
	localparam logic [11:0] IN_ADDR_A      = 12'hFD2;
	localparam logic [11:0] IN_ADDR_B      = 12'hFD6;
	localparam logic [11:0] IN_ADDR_C      = 12'hFDA;
	localparam logic [11:0] IN_ADDR_D      = 12'hFDE;
	localparam logic [1:0]  OFS_INDEX      = 2'h0;
	localparam logic [1:0]  OFS_CTRL       = 2'h1;
	localparam logic [1:0]  OFS_INPUT      = 2'h2;
	localparam int          NUM_IN_PORTS   = 3;

	localparam logic [7:0]  SUB_ALT_ENABLE = 8'h02;
	localparam logic [7:0]  SUB_WAKE       = 8'h05;
	localparam logic [7:0]  SUB_PULLUP     = 8'h06;
	localparam logic [7:0]  SUB_ALT_FIRST  = 8'h07;
	localparam logic [7:0]  SUB_ALT_SECOND = 8'h08;

	localparam logic [7:0]  RST_ZERO       = 8'h00;
	localparam logic [7:0]  RST_PORT_D     = 8'h01;
	localparam logic [7:0]  RST_SMALL_A    = 8'h04;
	localparam logic [7:0]  RST_INDEX      = 8'h00;
	localparam logic [31:0] PRESENT_28PIN  = 32'h01FF_FFFF;

endpackage : gpcs_pkg

// ---- hdl/gpcs_pin_sampler.sv ----
// two-flop pin synchroniser with a one-cycle toggle pulse per pin
// assumes pin levels are asynchronous to core_clk
module gpcs_pin_sampler #(
	parameter int WIDTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin_level,
	output logic      [WIDTH-1:0] sampled_ff,
	output logic      [WIDTH-1:0] toggled_ff
);
	import gpcs_pkg::*;

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] prev_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_ff    <= '0;
			sampled_ff <= '0;
		end else begin
			meta_ff    <= pin_level;
			sampled_ff <= meta_ff;
		end
	end

	// compare only settled samples, never the first stage
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev_ff    <= '0;
			toggled_ff <= '0;
		end else begin
			prev_ff    <= sampled_ff;
			toggled_ff <= sampled_ff ^ prev_ff;
		end
	end

endmodule : gpcs_pin_sampler

// ---- hdl/gpcs_gpio_cfg.sv ----
// per-port pin configuration subregisters, stop-mode wake detect and input levels
// assumes the cpu register strobes are synchronous to core_clk and one cycle wide
module gpcs_gpio_cfg #(
	parameter int          NUM_PORTS   = 4,
	parameter bit          IS_8PIN     = 1'b0,
	parameter logic [31:0] PIN_PRESENT = gpcs_pkg::PRESENT_28PIN
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic [11:0]            cpu_addr,
	input  wire logic                   cpu_wr,
	input  wire logic                   cpu_rd,
	input  wire logic [7:0]             cpu_wdata,
	output logic      [7:0]             cpu_rdata,
	input  wire logic                   stop_mode,
	input  wire logic [NUM_PORTS*8-1:0] pin_level,
	output logic      [NUM_PORTS*8-1:0] pullup_en,
	output logic      [NUM_PORTS*8-1:0] alt_active,
	output logic      [NUM_PORTS*16-1:0] alt_select,
	output logic                        stop_recovery
);
	import gpcs_pkg::*;

	localparam int NP = NUM_PORTS;

	logic [7:0]        index_ff   [NP];
	logic [7:0]        alt_en_ff  [NP];
	logic [7:0]        wake_ff    [NP];
	logic [7:0]        pullup_ff  [NP];
	logic [7:0]        alt1_ff    [NP];
	logic [7:0]        alt2_ff    [NP];
	logic [7:0]        port_rd    [NP];
	logic [NP*8-1:0]   sampled;
	logic [NP*8-1:0]   toggled;
	logic [NP*8-1:0]   wake_flat;
	logic [NP*8-1:0]   present;
	logic [NP*8-1:0]   pullup_en_ff;
	logic [NP*8-1:0]   alt_active_ff;
	logic [NP*16-1:0]  alt_select_ff;
	logic [7:0]        cpu_rdata_ff;
	logic [7:0]        nxt_rdata;
	logic              stop_recovery_ff;
	logic              page_hit;
	logic [1:0]        acc_port;
	logic [1:0]        acc_ofs;
	logic              wake_hit;

	assign present   = PIN_PRESENT[NP*8-1:0];
	assign page_hit  = (cpu_addr[11:4] == ADDR_PAGE);
	assign acc_port  = cpu_addr[3:2];
	assign acc_ofs   = cpu_addr[1:0];

	gpcs_pin_sampler #(
		.WIDTH (NP*8)
	) u_sampler (
		.core_clk   (core_clk),
		.rst        (rst),
		.pin_level  (pin_level),
		.sampled_ff (sampled),
		.toggled_ff (toggled)
	);

	genvar p;
	generate
		for (p = 0; p < NP; p++) begin : g_port
			localparam logic [7:0] RST_PULLUP = (p == 3) ? RST_PORT_D :
				((p == 0 && IS_8PIN) ? RST_SMALL_A : RST_ZERO);
			localparam logic [7:0] RST_ALT2 = (p == 0 && IS_8PIN) ? RST_SMALL_A : RST_ZERO;
			logic sel;
			logic wr_ctrl;

			assign sel     = page_hit && (acc_port == 2'(p));
			assign wr_ctrl = cpu_wr && sel && (acc_ofs == OFS_CTRL);
			assign wake_flat[p*8 +: 8] = wake_ff[p];

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					index_ff[p] <= RST_INDEX;
				end else if (cpu_wr && sel && acc_ofs == OFS_INDEX) begin
					index_ff[p] <= cpu_wdata;
				end
			end

			// enable subregister shares the pull-up reset pattern
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					alt_en_ff[p] <= RST_PULLUP;
				end else if (wr_ctrl && index_ff[p] == SUB_ALT_ENABLE) begin
					alt_en_ff[p] <= cpu_wdata;
				end
			end

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					wake_ff[p] <= RST_ZERO;
				end else if (wr_ctrl && index_ff[p] == SUB_WAKE) begin
					wake_ff[p] <= cpu_wdata;
				end
			end

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					pullup_ff[p] <= RST_PULLUP;
				end else if (wr_ctrl && index_ff[p] == SUB_PULLUP) begin
					pullup_ff[p] <= cpu_wdata;
				end
			end

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					alt1_ff[p] <= RST_ZERO;
				end else if (wr_ctrl && index_ff[p] == SUB_ALT_FIRST) begin
					alt1_ff[p] <= cpu_wdata;
				end
			end

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					alt2_ff[p] <= RST_ALT2;
				end else if (wr_ctrl && index_ff[p] == SUB_ALT_SECOND) begin
					alt2_ff[p] <= cpu_wdata;
				end
			end

			always_comb begin
				port_rd[p] = 8'h00;
				case (acc_ofs)
					OFS_INDEX: port_rd[p] = index_ff[p];
					OFS_CTRL: begin
						case (index_ff[p])
							SUB_ALT_ENABLE: port_rd[p] = alt_en_ff[p];
							SUB_WAKE:       port_rd[p] = wake_ff[p];
							SUB_PULLUP:     port_rd[p] = pullup_ff[p];
							SUB_ALT_FIRST:  port_rd[p] = alt1_ff[p];
							SUB_ALT_SECOND: port_rd[p] = alt2_ff[p];
							default:        port_rd[p] = 8'h00;
						endcase
					end
					OFS_INPUT: begin
						if (p < NUM_IN_PORTS) begin
							port_rd[p] = sampled[p*8 +: 8] & present[p*8 +: 8];
						end
					end
					default: port_rd[p] = 8'h00;
				endcase
			end

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					pullup_en_ff[p*8 +: 8] <= RST_PULLUP;
				end else begin
					pullup_en_ff[p*8 +: 8] <= pullup_ff[p];
				end
			end
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < NP*8; i++) begin : g_pin
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					alt_active_ff[i]       <= 1'b0;
					alt_select_ff[2*i +: 2] <= 2'b00;
				end else begin
					alt_active_ff[i]       <= alt_en_ff[i/8][i%8];
					alt_select_ff[2*i +: 2] <= alt_en_ff[i/8][i%8] ?
						{alt2_ff[i/8][i%8], alt1_ff[i/8][i%8]} : 2'b00;
				end
			end
		end
	endgenerate

	// unmapped or out-of-range ports read zero
	always_comb begin
		nxt_rdata = 8'h00;
		if (page_hit && int'(acc_port) < NP) begin
			nxt_rdata = port_rd[acc_port];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cpu_rdata_ff <= 8'h00;
		end else if (cpu_rd) begin
			cpu_rdata_ff <= nxt_rdata;
		end
	end

	assign wake_hit = |(toggled & wake_flat);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stop_recovery_ff <= 1'b0;
		end else begin
			stop_recovery_ff <= stop_mode && wake_hit;
		end
	end

	assign cpu_rdata     = cpu_rdata_ff;
	assign pullup_en     = pullup_en_ff;
	assign alt_active    = alt_active_ff;
	assign alt_select    = alt_select_ff;
	assign stop_recovery = stop_recovery_ff;

	// checking helpers: has port A or D control register been written since reset, through any index
	logic pullup_a_touched_ff;
	logic pullup_d_touched_ff;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pullup_a_touched_ff <= 1'b0;
			pullup_d_touched_ff <= 1'b0;
		end else begin
			if (cpu_wr && cpu_addr == {ADDR_PAGE, 2'd0, OFS_CTRL}) begin
				pullup_a_touched_ff <= 1'b1;
			end
			if (cpu_wr && cpu_addr == {ADDR_PAGE, 2'd3, OFS_CTRL}) begin
				pullup_d_touched_ff <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_wake_start;
		stop_mode && |(toggled & wake_flat) |=> stop_recovery;
	endproperty
	a_wake_start: assert property (p_wake_start)
		else $error("enabled toggle in stop mode did not wake");

	property p_no_wake;
		stop_recovery |-> $past(stop_mode) && ($past(toggled) & $past(wake_flat)) != '0;
	endproperty
	a_no_wake: assert property (p_no_wake)
		else $error("wake raised without an enabled toggle");

	property p_pullup_route;
		cpu_wr && cpu_addr == {ADDR_PAGE, 2'd1, OFS_CTRL} && index_ff[1] == SUB_PULLUP
			|=> pullup_ff[1] == $past(cpu_wdata) ##1 pullup_en[15:8] == $past(cpu_wdata, 2);
	endproperty
	a_pullup_route: assert property (p_pullup_route)
		else $error("pull-up write through index 06 not applied");

	property p_pullup_reset;
		!pullup_a_touched_ff && !pullup_d_touched_ff |->
			pullup_ff[0] == (IS_8PIN ? RST_SMALL_A : RST_ZERO) && pullup_ff[NP-1] ==
			(NP == 4 ? RST_PORT_D : RST_ZERO);
	endproperty
	a_pullup_reset: assert property (p_pullup_reset)
		else $error("pull-up reset value wrong");

	property p_alt1_route;
		cpu_wr && cpu_addr == {ADDR_PAGE, 2'd0, OFS_CTRL} && index_ff[0] == SUB_ALT_FIRST
			|=> alt1_ff[0] == $past(cpu_wdata);
	endproperty
	a_alt1_route: assert property (p_alt1_route)
		else $error("first select write through index 07 not applied");

	property p_alt2_route;
		cpu_wr && cpu_addr == {ADDR_PAGE, 2'd0, OFS_CTRL} && index_ff[0] == SUB_ALT_SECOND
			|=> alt2_ff[0] == $past(cpu_wdata);
	endproperty
	a_alt2_route: assert property (p_alt2_route)
		else $error("second select write through index 08 not applied");

	property p_alt_gate;
		##1 alt_select[1:0] == ($past(alt_en_ff[0][0]) ?
			{$past(alt2_ff[0][0]), $past(alt1_ff[0][0])} : 2'b00);
	endproperty
	a_alt_gate: assert property (p_alt_gate)
		else $error("alternate select not gated by enable");

	property p_input_read;
		cpu_rd && cpu_addr == IN_ADDR_B |=> cpu_rdata == $past(sampled[15:8] & present[15:8]);
	endproperty
	a_input_read: assert property (p_input_read)
		else $error("input level read mismatch");

	property p_missing_zero;
		cpu_rd && cpu_addr == IN_ADDR_D |=> cpu_rdata == 8'h00;
	endproperty
	a_missing_zero: assert property (p_missing_zero)
		else $error("absent input port read nonzero");

	c_wake:   cover property (stop_recovery);
	c_alt:    cover property (alt_active[0] && alt_select[1:0] == 2'b11);
	c_pullup: cover property (cpu_wr && acc_ofs == OFS_CTRL && index_ff[0] == SUB_PULLUP);
	c_input:  cover property (cpu_rd && cpu_addr == IN_ADDR_A);

endmodule : gpcs_gpio_cfg

// ---- tb/testbench.sv ----
// self-checking bench for the pin configuration subregisters and input levels
// assumes gpcs_gpio_cfg with its default parameters: four ports, 28-pin present mask
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import gpcs_pkg::*;

	logic        core_clk;
	logic        rst;
	logic [11:0] cpu_addr;
	logic        cpu_wr;
	logic        cpu_rd;
	logic [7:0]  cpu_wdata;
	logic [7:0]  cpu_rdata;
	logic        stop_mode;
	logic [31:0] pin_level;
	logic [31:0] pullup_en;
	logic [31:0] alt_active;
	logic [63:0] alt_select;
	logic        stop_recovery;
	int          n_mismatch;
	int          checked;

	gpcs_gpio_cfg gpcs_gpio_cfg_i (
		.core_clk      (core_clk),
		.rst           (rst),
		.cpu_addr      (cpu_addr),
		.cpu_wr        (cpu_wr),
		.cpu_rd        (cpu_rd),
		.cpu_wdata     (cpu_wdata),
		.cpu_rdata     (cpu_rdata),
		.stop_mode     (stop_mode),
		.pin_level     (pin_level),
		.pullup_en     (pullup_en),
		.alt_active    (alt_active),
		.alt_select    (alt_select),
		.stop_recovery (stop_recovery)
	);

	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge core_clk);
		cpu_addr  = a;
		cpu_wdata = d;
		cpu_wr    = 1'b1;
		@(negedge core_clk);
		cpu_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
		@(negedge core_clk);
		cpu_addr = a;
		cpu_rd   = 1'b1;
		@(negedge core_clk);
		cpu_rd = 1'b0;
		chk(name, 64'(exp), 64'(cpu_rdata));
	endtask : rd

	function automatic logic [11:0] reg_addr(input int p, input logic [1:0] ofs);
		return {ADDR_PAGE, 2'(p), ofs};
	endfunction : reg_addr

	task automatic sub_wr(input int p, input logic [7:0] idx, input logic [7:0] d);
		wr(reg_addr(p, OFS_INDEX), idx);
		wr(reg_addr(p, OFS_CTRL), d);
	endtask : sub_wr

	task automatic sub_rd(input int p, input logic [7:0] idx, input logic [7:0] exp);
		wr(reg_addr(p, OFS_INDEX), idx);
		rd(reg_addr(p, OFS_CTRL), exp, "subregister");
	endtask : sub_rd

	// counts wake pulses over a fixed window, sampled mid-cycle
	task automatic pulses(input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			@(negedge core_clk);
			if (stop_recovery === 1'b1) cnt++;
		end
	endtask : pulses

	task automatic test_reset();
		for (int p = 0; p < 4; p++) begin
			sub_rd(p, SUB_PULLUP, (p == 3) ? RST_PORT_D : RST_ZERO);
			sub_rd(p, SUB_ALT_FIRST, RST_ZERO);
			sub_rd(p, SUB_ALT_SECOND, RST_ZERO);
			sub_rd(p, SUB_ALT_ENABLE, (p == 3) ? RST_PORT_D : RST_ZERO);
			sub_rd(p, SUB_WAKE, RST_ZERO);
		end
		chk("pullup_en", 64'h0100_0000, 64'(pullup_en));
		// port D pin 0 comes out of reset with its alternate function enabled
		chk("alt_active", 64'h0100_0000, 64'(alt_active));
		chk("alt_select", 64'h0, 64'(alt_select));
		$display("test reset done");
	endtask : test_reset

	task automatic test_readback();
		logic [7:0] idx [3];
		idx = '{SUB_PULLUP, SUB_ALT_FIRST, SUB_ALT_SECOND};
		for (int p = 0; p < 4; p++) begin
			for (int i = 0; i < 3; i++) begin
				sub_wr(p, idx[i], 8'(8'hA5 ^ (p * 16 + i)));
			end
		end
		for (int p = 0; p < 4; p++) begin
			for (int i = 0; i < 3; i++) begin
				sub_rd(p, idx[i], 8'(8'hA5 ^ (p * 16 + i)));
			end
		end
		sub_wr(1, SUB_PULLUP, 8'h5A);
		@(negedge core_clk);
		chk("pullup_en", 64'h9585_5AA5, 64'(pullup_en));
		sub_wr(1, SUB_PULLUP, 8'h00);
		@(negedge core_clk);
		chk("pullup_en", 64'h9585_00A5, 64'(pullup_en));
		$display("test readback done");
	endtask : test_readback

	task automatic test_alt();
		logic [15:0] exp;
		sub_wr(2, SUB_ALT_FIRST, 8'h0F);
		sub_wr(2, SUB_ALT_SECOND, 8'h33);
		sub_wr(2, SUB_ALT_ENABLE, 8'h00);
		@(negedge core_clk);
		chk("alt_select", 64'h0, 64'(alt_select[47:32]));
		chk("alt_active", 64'h0, 64'(alt_active[23:16]));
		sub_wr(2, SUB_ALT_ENABLE, 8'hFF);
		@(negedge core_clk);
		for (int i = 0; i < 8; i++) begin
			exp[2*i+:2] = {1'(8'h33 >> i), 1'(8'h0F >> i)};
		end
		chk("alt_select", 64'(exp), 64'(alt_select[47:32]));
		chk("alt_active", 64'hFF, 64'(alt_active[23:16]));
		$display("test alt done");
	endtask : test_alt

	task automatic test_input();
		pin_level = 32'h7EC3_5AA5;
		repeat (4) @(negedge core_clk);
		rd(IN_ADDR_A, 8'hA5, "input a");
		rd(IN_ADDR_B, 8'h5A, "input b");
		rd(IN_ADDR_C, 8'hC3, "input c");
		rd(IN_ADDR_D, 8'h00, "input d");
		wr(IN_ADDR_A, 8'hFF);
		rd(IN_ADDR_A, 8'hA5, "input a");
		rd(12'hFD3, 8'h00, "unmapped");
		$display("test input done");
	endtask : test_input

	task automatic test_wake();
		int cnt;
		sub_wr(0, SUB_WAKE, 8'h01);
		sub_rd(0, SUB_WAKE, 8'h01);
		stop_mode = 1'b1;
		pin_level[0] = ~pin_level[0];
		pulses(8, cnt);
		chk("wake enabled", 64'd1, 64'(cnt));
		pin_level[1] = ~pin_level[1];
		pulses(8, cnt);
		chk("wake disabled", 64'd0, 64'(cnt));
		stop_mode = 1'b0;
		pin_level[0] = ~pin_level[0];
		pulses(8, cnt);
		chk("wake awake", 64'd0, 64'(cnt));
		$display("test wake done");
	endtask : test_wake

	// whole run is a few hundred cycles; this leaves ample margin
	initial begin
		#2_000_000;
		n_mismatch++;
		$display("ERROR watchdog expected finish seen timeout");
		test_done();
	end

	initial begin
		n_mismatch = 0;
		checked    = 0;
		rst        = 1'b1;
		cpu_addr   = 12'h000;
		cpu_wr     = 1'b0;
		cpu_rd     = 1'b0;
		cpu_wdata  = 8'h00;
		stop_mode  = 1'b0;
		pin_level  = 32'h0000_0000;
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge core_clk);
		test_reset();
		test_readback();
		test_alt();
		test_input();
		test_wake();
		test_done();
	end
endmodule : testbench
